// File: core/wide_write_pkg.sv
// shared constants for the wide write master and its local-side driver
package wide_write_pkg;
    localparam int ADDR_W       = 32;
    localparam int DATA_W       = 64;
    localparam int BE_W         = 8;
    localparam int BEATS_W      = 4;
    localparam int FIFO_W       = DATA_W + BE_W;
    localparam int FIFO_DEPTH   = 8;
    localparam logic [BEATS_W-1:0] FALLBACK_BEATS = 4'h2;
    localparam logic [BEATS_W-1:0] BEATS_RESET    = 4'h0;
    localparam logic [3:0]  CMD_MEM_WRITE = 4'h7;

    typedef enum logic [3:0] {
        TXN_IDLE      = 4'h0,
        TXN_ADDR_LOAD = 4'h1,
        TXN_BUS       = 4'h2,
        TXN_TERM      = 4'h3
    } txn_state_e;

    typedef enum logic [1:0] {
        END_NONE   = 2'h0,
        END_NORMAL = 2'h1
    } end_reason_e;
endpackage

// File: core/wide_write_if.sv
// local-side link between the local master and the wide write master
`timescale 1ns/1ps
interface wide_write_if;
    import wide_write_pkg::*;
    logic                 local_wide_request_n;
    logic [ADDR_W-1:0]    local_addr_in;
    logic [3:0]           local_cmd_in;
    logic [BEATS_W-1:0]   requested_beats;
    logic [DATA_W-1:0]    local_data_in;
    logic [BE_W-1:0]      local_cmd_byteen_in;
    logic                 local_ready_n;
    logic                 local_grant_n;
    logic [3:0]           local_txn_state;
    logic                 low_word_take_n;
    logic                 high_word_take_n;
    logic                 wide_txn_active_n;
    logic [1:0]           end_reason;

    modport core (
        input  local_wide_request_n, local_addr_in, local_cmd_in, requested_beats,
        input  local_data_in, local_cmd_byteen_in, local_ready_n,
        output local_grant_n, local_txn_state, low_word_take_n, high_word_take_n,
        output wide_txn_active_n, end_reason
    );
    modport local_master (
        output local_wide_request_n, local_addr_in, local_cmd_in, requested_beats,
        output local_data_in, local_cmd_byteen_in, local_ready_n,
        input  local_grant_n, local_txn_state, low_word_take_n, high_word_take_n,
        input  wide_txn_active_n, end_reason
    );
endinterface

// File: core/word_fifo.sv
// parameterised valid/ready fifo
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr_reg] <= in_data;
                wr_ptr_reg      <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: core/wide_write_master.sv
// pci master end: wide write request with 32-bit width fallback
`timescale 1ns/1ps
module wide_write_master
    import wide_write_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    rst_b,
    wide_write_if.core   lm,
    output logic         reqn,
    input  wire logic    gntn,
    input  wire logic    framen_in,
    input  wire logic    irdyn_in,
    output logic         framen_out,
    output logic         framen_oe_n,
    output logic         req64n_out,
    output logic         req64n_oe_n,
    output logic         irdyn_out,
    output logic         irdyn_oe_n,
    output logic [63:0]  ad_out,
    output logic         ad_lo_oe_n,
    output logic         ad_hi_oe_n,
    output logic [7:0]   cben_out,
    output logic         cben_lo_oe_n,
    output logic         cben_hi_oe_n,
    input  wire logic    devseln,
    input  wire logic    trdyn,
    input  wire logic    ack64n
);
    typedef struct packed {
        txn_state_e          txn;
        end_reason_e         why;
        logic                reqn;
        logic                grant_n;
        logic                wide_n;
        logic                lo_take_n;
        logic                hi_take_n;
        logic [BEATS_W-1:0]  beats;
        logic [ADDR_W-1:0]   addr;
        logic [3:0]          cmd;
        logic                framen;
        logic                req64n;
        logic                irdyn;
        logic                drive;
        logic                drive_hi;
        logic                irdy_drive;
        logic                data_out;
        logic                upper_sent;
        logic [63:0]         ad;
        logic [7:0]          cben;
        logic                req_prev;
        logic                gnt_prev;
        logic                rdy_prev;
        logic                dev_prev;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic   done_phase;
    logic   fifo_in_ready;
    logic   fifo_valid;
    logic   fifo_pop;
    logic [FIFO_W-1:0] fifo_data;

    // the fifo decouples the local write data from the pci data phases
    word_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) data_q (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (!st_reg.lo_take_n && !st_reg.hi_take_n),
        .in_ready  (fifo_in_ready),
        .in_data   ({lm.local_cmd_byteen_in, lm.local_data_in}),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    assign done_phase = !st_reg.irdyn && !trdyn && st_reg.irdy_drive;
    assign fifo_pop   = done_phase && st_reg.upper_sent && fifo_valid;

    always_comb
    begin
        st_next          = st_reg;
        st_next.req_prev = !lm.local_wide_request_n;
        st_next.gnt_prev = !gntn;
        st_next.rdy_prev = !lm.local_ready_n;
        st_next.dev_prev = !devseln;
        st_next.lo_take_n = 1'b1;
        st_next.hi_take_n = 1'b1;
        if (!lm.local_wide_request_n && st_reg.txn != TXN_BUS)
            st_next.reqn = 1'b0;
        if (!framen_in && st_reg.framen == 1'b0 && lm.local_wide_request_n)
            st_next.reqn = 1'b1;
        if (st_reg.txn == TXN_IDLE || st_reg.txn == TXN_TERM)
            st_next.grant_n = !(!gntn && framen_in && irdyn_in);
        else
            st_next.grant_n = gntn;
        case (st_reg.txn)
            TXN_IDLE, TXN_TERM:
            begin
                if (st_reg.txn == TXN_TERM)
                    st_next.txn = TXN_IDLE;
                st_next.drive      = 1'b0;
                st_next.drive_hi   = 1'b0;
                st_next.irdy_drive = 1'b0;
                st_next.irdyn      = 1'b1;
                if (st_reg.req_prev && st_reg.gnt_prev && framen_in && irdyn_in)
                begin
                    st_next.txn    = TXN_ADDR_LOAD;
                    st_next.addr   = lm.local_addr_in;
                    st_next.cmd    = lm.local_cmd_in;
                    st_next.beats  = lm.requested_beats;
                    st_next.wide_n = 1'b0;
                    st_next.why    = END_NONE;
                end
            end
            TXN_ADDR_LOAD:
            begin
                if (st_reg.gnt_prev)
                begin
                    st_next.txn        = TXN_BUS;
                    st_next.framen     = 1'b0;
                    st_next.req64n     = 1'b0;
                    st_next.drive      = 1'b1;
                    st_next.ad         = {32'h0, st_reg.addr};
                    st_next.cben       = {4'h0, st_reg.cmd};
                    st_next.data_out   = 1'b0;
                    st_next.upper_sent = 1'b0;
                    st_next.beats      = lm.requested_beats;
                    if (!lm.local_ready_n && fifo_in_ready)
                    begin
                        st_next.lo_take_n = 1'b0;
                        st_next.hi_take_n = 1'b0;
                    end
                end
            end
            TXN_BUS:
            begin
                if (!st_reg.lo_take_n && !st_reg.hi_take_n)
                begin
                    st_next.ad       = lm.local_data_in;
                    st_next.cben     = lm.local_cmd_byteen_in;
                    st_next.drive_hi = 1'b1;
                    st_next.data_out = 1'b1;
                end
                if (!devseln && !trdyn && ack64n && !st_reg.wide_n)
                begin
                    st_next.wide_n = 1'b1;
                    st_next.beats  = FALLBACK_BEATS;
                end
                if (st_reg.dev_prev && st_reg.rdy_prev && st_reg.data_out)
                begin
                    st_next.irdyn      = 1'b0;
                    st_next.irdy_drive = 1'b1;
                end
                if (done_phase)
                begin
                    st_next.beats = st_reg.beats - 1'b1;
                    if (st_reg.beats <= 4'h1)
                    begin
                        st_next.txn      = TXN_TERM;
                        st_next.why      = END_NORMAL;
                        st_next.framen   = 1'b1;
                        st_next.req64n   = 1'b1;
                        st_next.drive    = 1'b0;
                        st_next.drive_hi = 1'b0;
                        st_next.irdyn    = 1'b1;
                        st_next.beats    = BEATS_RESET;
                    end
                    else
                    begin
                        // upper word moves to the low lanes for the second phase
                        st_next.ad         = {32'h0, fifo_data[63:32]};
                        st_next.cben       = {4'h0, fifo_data[71:68]};
                        st_next.drive_hi   = 1'b0;
                        st_next.upper_sent = 1'b1;
                        st_next.framen     = 1'b0;
                        if (st_reg.beats == 4'h2)
                            st_next.framen = 1'b1;
                    end
                end
            end
            default:
            begin
                st_next.txn = TXN_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st_reg           <= '0;
            st_reg.txn       <= TXN_IDLE;
            st_reg.why       <= END_NONE;
            st_reg.reqn      <= 1'b1;
            st_reg.grant_n   <= 1'b1;
            st_reg.wide_n    <= 1'b1;
            st_reg.lo_take_n <= 1'b1;
            st_reg.hi_take_n <= 1'b1;
            st_reg.framen    <= 1'b1;
            st_reg.req64n    <= 1'b1;
            st_reg.irdyn     <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reqn                 = st_reg.reqn;
    assign framen_out           = st_reg.framen;
    assign req64n_out           = st_reg.req64n;
    assign irdyn_out            = st_reg.irdyn;
    assign ad_out               = st_reg.ad;
    assign cben_out             = st_reg.cben;
    // frame is released right after the last data phase; only irdy stays driven one cycle longer
    assign framen_oe_n          = !st_reg.drive;
    assign req64n_oe_n          = !st_reg.drive;
    assign irdyn_oe_n           = !(st_reg.drive || st_reg.irdy_drive);
    assign ad_lo_oe_n           = !st_reg.drive;
    assign cben_lo_oe_n         = !st_reg.drive;
    assign ad_hi_oe_n           = !st_reg.drive_hi;
    assign cben_hi_oe_n         = !st_reg.drive_hi;
    assign lm.local_grant_n     = st_reg.grant_n;
    assign lm.local_txn_state   = st_reg.txn;
    assign lm.low_word_take_n   = st_reg.lo_take_n;
    assign lm.high_word_take_n  = st_reg.hi_take_n;
    assign lm.wide_txn_active_n = st_reg.wide_n;
    assign lm.end_reason        = st_reg.why;
endmodule

// File: core/local_write_master.sv
// local master end: issues one wide write per start pulse
`timescale 1ns/1ps
module local_write_master
    import wide_write_pkg::*;
(
    input  wire logic                clock,
    input  wire logic                rst_b,
    wide_write_if.local_master       lm,
    input  wire logic                start,
    input  wire logic [ADDR_W-1:0]   addr,
    input  wire logic [BEATS_W-1:0]  beats,
    input  wire logic [DATA_W-1:0]   data,
    input  wire logic [BE_W-1:0]     byteen,
    input  wire logic                data_valid,
    output logic                     busy,
    output logic                     done
);
    typedef struct packed {
        logic                req_n;
        logic                rdy_n;
        logic                busy;
        logic                done;
        logic [ADDR_W-1:0]   addr;
        logic [BEATS_W-1:0]  beats;
        logic [DATA_W-1:0]   data;
        logic [BE_W-1:0]     be;
    } state_s;

    state_s st_reg;
    state_s st_next;

    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (start && !st_reg.busy)
        begin
            st_next.req_n = 1'b0;
            st_next.busy  = 1'b1;
            st_next.addr  = addr;
            st_next.beats = beats;
            st_next.data  = data;
            st_next.be    = byteen;
        end
        if (lm.local_txn_state == TXN_ADDR_LOAD)
            st_next.req_n = 1'b1;
        // ready only once write data is held, and kept through the burst: irdyn waits on it
        if (st_reg.busy && data_valid)
            st_next.rdy_n = 1'b0;
        if (st_reg.busy && lm.local_txn_state == TXN_TERM)
        begin
            st_next.busy  = 1'b0;
            st_next.done  = 1'b1;
            st_next.rdy_n = 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            st_reg       <= '0;
            st_reg.req_n <= 1'b1;
            st_reg.rdy_n <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign lm.local_wide_request_n = st_reg.req_n;
    assign lm.local_addr_in        = st_reg.addr;
    assign lm.local_cmd_in         = CMD_MEM_WRITE;
    assign lm.requested_beats      = st_reg.beats;
    assign lm.local_data_in        = st_reg.data;
    assign lm.local_cmd_byteen_in  = st_reg.be;
    assign lm.local_ready_n        = st_reg.rdy_n;
    assign busy                    = st_reg.busy;
    assign done                    = st_reg.done;
endmodule

// File: tb/wide_write_props.sv
// concurrent checks on the local link and the pci master pins
`timescale 1ns/1ps
module wide_write_props
    import wide_write_pkg::*;
(
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       local_wide_request_n,
    input wire logic       local_ready_n,
    input wire logic       local_grant_n,
    input wire logic [3:0] local_txn_state,
    input wire logic       low_word_take_n,
    input wire logic       high_word_take_n,
    input wire logic       wide_txn_active_n,
    input wire logic [1:0] end_reason,
    input wire logic       reqn,
    input wire logic       gntn,
    input wire logic       framen_in,
    input wire logic       irdyn_in,
    input wire logic       framen_oe_n,
    input wire logic       req64n_oe_n,
    input wire logic       ad_lo_oe_n,
    input wire logic       ad_hi_oe_n,
    input wire logic       devseln,
    input wire logic       trdyn,
    input wire logic       ack64n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_req; !local_wide_request_n && framen_in |=> !reqn; endproperty
    a_req: assert property (p_req) else $error("no bus request");
    property p_grant; !gntn && framen_in && irdyn_in |=> !local_grant_n; endproperty
    a_grant: assert property (p_grant) else $error("no local grant");
    property p_follow; gntn |=> local_grant_n; endproperty
    a_follow: assert property (p_follow) else $error("grant not following");
    property p_load;
        !local_wide_request_n && !gntn && local_txn_state == TXN_IDLE
            |-> ##[1:2] local_txn_state == TXN_ADDR_LOAD;
    endproperty
    a_load: assert property (p_load) else $error("no address load");
    property p_drop; local_txn_state == TXN_ADDR_LOAD |=> local_wide_request_n; endproperty
    a_drop: assert property (p_drop) else $error("request held");
    property p_addr;
        local_txn_state == TXN_ADDR_LOAD && !gntn
            |=> !framen_in && !req64n_oe_n && local_txn_state == TXN_BUS;
    endproperty
    a_addr: assert property (p_addr) else $error("no address phase");
    property p_take;
        local_txn_state == TXN_ADDR_LOAD && !gntn && !local_ready_n
            |=> !low_word_take_n && !high_word_take_n;
    endproperty
    a_take: assert property (p_take) else $error("words not taken");
    property p_lanes; !low_word_take_n && !high_word_take_n |=> !ad_hi_oe_n; endproperty
    a_lanes: assert property (p_lanes) else $error("upper lanes idle");
    property p_unreq; !framen_in && local_wide_request_n |=> reqn; endproperty
    a_unreq: assert property (p_unreq) else $error("reqn held");
    property p_fall; !devseln && !trdyn && ack64n && !wide_txn_active_n |=> wide_txn_active_n;
    endproperty
    a_fall: assert property (p_fall) else $error("no width fallback");
    property p_hold; $rose(wide_txn_active_n) |-> !framen_in; endproperty
    a_hold: assert property (p_hold) else $error("frame dropped early");
    property p_irdy; $fell(devseln) |-> ##[1:2] !irdyn_in; endproperty
    a_irdy: assert property (p_irdy) else $error("no initiator ready");
    property p_last;
        framen_in && !irdyn_in && !trdyn
            |=> local_txn_state == TXN_TERM && end_reason == END_NORMAL;
    endproperty
    a_last: assert property (p_last) else $error("no normal end");
    property p_rel; local_txn_state == TXN_TERM |-> framen_oe_n && req64n_oe_n && ad_lo_oe_n;
    endproperty
    a_rel: assert property (p_rel) else $error("bus not released");
    c_term: cover property (local_txn_state == TXN_TERM);
    c_fall: cover property ($rose(wide_txn_active_n));
    c_take: cover property (!low_word_take_n);
endmodule

// File: tb/testbench.sv
// both ends joined against a 32-bit-only target
`timescale 1ns/1ps
module testbench
    import wide_write_pkg::*;
;
    typedef struct packed {logic [31:0] a; logic [63:0] d; logic [7:0] b;} row_s;
    row_s rows [3] = '{'{32'h0000_1000, 64'h0123_4567_89ab_cdef, 8'hff},
                       '{32'hffff_fffc, 64'hffff_0000_a5a5_5a5a, 8'h0f},
                       '{32'h0000_0000, 64'h8000_0000_0000_0001, 8'hf0}};
    logic clock = 1'b0, rst_b = 1'b0, start = 1'b0, data_valid = 1'b1, busy, done;
    logic gntn = 1'b1, devseln = 1'b1, trdyn = 1'b1, ack64n = 1'b1, fr_q = 1'b1;
    logic [ADDR_W-1:0]  addr = '0;
    logic [BEATS_W-1:0] beats = 4'h1;
    logic [DATA_W-1:0]  data = '0;
    logic [BE_W-1:0]    byteen = '0;
    logic reqn, framen_out, framen_oe_n, req64n_out, req64n_oe_n, irdyn_out, irdyn_oe_n;
    logic ad_lo_oe_n, ad_hi_oe_n, cben_lo_oe_n, cben_hi_oe_n;
    logic [63:0] ad_out;
    logic [7:0]  cben_out;
    logic [35:0] cap [$];
    logic [35:0] hi_q = '0;
    logic hi_off = 1'b0;
    int n_errors = 0, checks = 0, n_take = 0;
    // pulled-up lines read high when released
    wire framen_in = framen_oe_n ? 1'b1 : framen_out;
    wire irdyn_in = irdyn_oe_n ? 1'b1 : irdyn_out;
    wire [35:0] lanes = {cben_lo_oe_n ? 4'hz : cben_out[3:0], ad_lo_oe_n ? 32'hz : ad_out[31:0]};
    wire [35:0] hi_lanes = {cben_hi_oe_n ? 4'hz : cben_out[7:4],
                            ad_hi_oe_n ? 32'hz : ad_out[63:32]};
    wide_write_if lm ();
    initial forever #4 clock = ~clock;
    wide_write_master wide_write_master_i (.clock(clock), .rst_b(rst_b), .lm(lm), .reqn(reqn),
        .gntn(gntn), .framen_in(framen_in), .irdyn_in(irdyn_in), .framen_out(framen_out),
        .framen_oe_n(framen_oe_n), .req64n_out(req64n_out), .req64n_oe_n(req64n_oe_n),
        .irdyn_out(irdyn_out), .irdyn_oe_n(irdyn_oe_n), .ad_out(ad_out),
        .ad_lo_oe_n(ad_lo_oe_n), .ad_hi_oe_n(ad_hi_oe_n), .cben_out(cben_out),
        .cben_lo_oe_n(cben_lo_oe_n), .cben_hi_oe_n(cben_hi_oe_n), .devseln(devseln),
        .trdyn(trdyn), .ack64n(ack64n));
    local_write_master local_write_master_i (.clock(clock), .rst_b(rst_b), .lm(lm),
        .start(start), .addr(addr), .beats(beats), .data(data), .byteen(byteen),
        .data_valid(data_valid), .busy(busy), .done(done));
    wide_write_props wide_write_props_i (.clock(clock), .rst_b(rst_b),
        .local_wide_request_n(lm.local_wide_request_n), .local_ready_n(lm.local_ready_n),
        .local_grant_n(lm.local_grant_n), .local_txn_state(lm.local_txn_state),
        .low_word_take_n(lm.low_word_take_n), .high_word_take_n(lm.high_word_take_n),
        .wide_txn_active_n(lm.wide_txn_active_n), .end_reason(lm.end_reason), .reqn(reqn),
        .gntn(gntn), .framen_in(framen_in), .irdyn_in(irdyn_in), .framen_oe_n(framen_oe_n),
        .req64n_oe_n(req64n_oe_n), .ad_lo_oe_n(ad_lo_oe_n), .ad_hi_oe_n(ad_hi_oe_n),
        .devseln(devseln), .trdyn(trdyn), .ack64n(ack64n));
    // arbiter grants one cycle after the request; target claims 32 bits only
    always @(posedge clock)
    begin
        gntn <= rst_b ? reqn : 1'b1;
        devseln <= !rst_b || framen_in;
        trdyn <= !rst_b || framen_in;
        if (rst_b && !framen_in && fr_q)
            cap.push_back(lanes);
        if (rst_b && !irdyn_in && !trdyn)
        begin
            // upper lanes carry data in the first phase only; the fifo feeds the second
            if (cap.size() == 1)
                hi_q = hi_lanes;
            else
                hi_off = ad_hi_oe_n && cben_hi_oe_n;
            cap.push_back(lanes);
        end
        if (rst_b && !lm.low_word_take_n && !lm.high_word_take_n)
            n_take++;
        fr_q <= framen_in;
    end
    task results;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [35:0] got, input logic [35:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic run(input logic [31:0] a, input logic [63:0] d, input logic [7:0] b);
        logic hit;
        hit = 1'b0;
        cap.delete();
        n_take = 0;
        hi_q = '0;
        hi_off = 1'b0;
        @(posedge clock);
        addr <= a;
        data <= d;
        byteen <= b;
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        for (int i = 0; i < 80 && !hit; i++)
        begin
            @(negedge clock);
            hit = (done === 1'b1);
        end
        if (!hit)
        begin
            n_errors++;
            $display("[ERR] %0t no completion", $time);
            results();
        end
        chk(36'(cap.size()), 36'h3, "phase count");
        if (cap.size() == 3)
        begin
            chk(cap[0], {CMD_MEM_WRITE, a}, "address phase");
            chk(cap[1], {b[3:0], d[31:0]}, "first phase");
            chk(cap[2], {b[7:4], d[63:32]}, "second phase");
        end
        chk(36'(lm.end_reason), 36'(END_NORMAL), "end reason");
        chk(36'(lm.wide_txn_active_n), 36'h1, "wide flag");
        chk(36'(reqn), 36'h1, "bus request");
        chk(36'({framen_oe_n, req64n_oe_n, ad_lo_oe_n}), 36'h7, "release");
        chk(hi_q, {b[7:4], d[63:32]}, "upper lanes");
        chk(36'(hi_off), 36'h1, "upper lanes released");
        chk(36'(n_take), 36'h1, "single take");
        chk(36'(lm.local_grant_n), 36'h1, "grant follows");
    endtask
    initial
    begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        foreach (rows[i])
            run(rows[i].a, rows[i].d, rows[i].b);
        // reset in mid-transfer must drop reqn, the frame and irdy enables and the local grant back to idle
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        repeat (4) @(posedge clock);
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk(36'({reqn, framen_oe_n, irdyn_oe_n, lm.local_grant_n}), 36'hf, "reset idle");
        @(posedge clock);
        rst_b <= 1'b1;
        run(rows[1].a, rows[1].d, rows[1].b);
        results();
    end
endmodule
